// ===== rtl/arsr_regs.sv
// Contract
// - Bit 0 reads 1 while request in progress
// - 8-bit error count, cleared by 0x28 write
// - 8-bit request count, cleared by 0x28 write
// - Writing bit 0 pulses hot-plug output low
// - Pulse duration from bits 31:16 in microseconds
// - Hot-plug command register always reads zero
// - Report sync half-period in clock cycles
// - Capture latest request command, four bits
// - Capture latest request address, twenty bits
// - I2C requests keep seven address bits only
// - Length stored as byte count minus one
// - Lengths from one to sixteen bytes
// - Address-only request reports length zero
// - Reading cause register returns then clears it
// - Writing cause register clears all bits too
// - Causes 31,30,29: unplug, CRC, ACT
// - Cause 28: payload allocation table written
// - Cause 27: audio FIFO overflow
// - Causes 18,17,16: training patterns 3,2,1
// - Cause 15: link bandwidth changed
// - Cause 14: link training done
// - Mask at 0x044 gates interrupt, resets ones
module arsr_regs
  import arsr_pkg::*;
#(
  parameter logic [15:0] HPD_ZERO_US = HPD_DEFAULT_US
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic auxLinkClk,
  input wire arsr_req_t auxReq,
  input wire arsr_evt_t linkEvt,
  output logic hpdN,
  output logic hostIrq
);

  typedef enum logic {HPD_IDLE, HPD_PULSE} arsr_hpd_t;

  // Bus address and data phases
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;

  wire addrPhase = hsel && hready && (htrans == 2'(HTRANS_NONSEQ) || htrans == 2'(HTRANS_SEQ));
  wire rdTake = addrPhase && !hwrite;
  wire wrTake = addrPhase && hwrite;
  wire [7:0] rdAddr = haddr[7:0];
  wire inRange = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  wire wrDone = wrPend_q && hready;

  wire wrReqTally = wrDone && (wrAddr_q == OFF_REQ_TALLY);
  wire wrHpd = wrDone && (wrAddr_q == OFF_HPD_CMD);
  wire wrCause = wrDone && (wrAddr_q == OFF_CAUSE);
  wire wrMask = wrDone && (wrAddr_q == OFF_MASK);
  wire rdCause = rdTake && inRange && (rdAddr == OFF_CAUSE);

  // Register state
  logic [7:0] errTally_q;
  logic [7:0] reqTally_q;
  logic [9:0] syncHalf_q;
  logic [3:0] lastCmd_q;
  logic [19:0] lastAddr_q;
  logic [3:0] lastLen_q;
  logic [31:0] cause_q;
  logic [31:0] mask_q;
  logic hostIrq_q;
  logic hresp_q;

  // Link clock sampling and edge timing
  logic [2:0] linkSync_q;
  logic linkLvl_q;
  logic [9:0] halfCnt_q;
  logic syncEdgeSeen_q;

  wire linkStable = linkSync_q[1] == linkSync_q[2];
  wire linkEdge = linkStable && (linkSync_q[2] != linkLvl_q);
  wire [9:0] halfCnt_d = linkEdge ? 10'h000 : (halfCnt_q == HALF_MAX ? HALF_MAX : halfCnt_q + 10'h001);
  wire captureHalf = linkEdge && auxReq.inSync && syncEdgeSeen_q;
  wire [9:0] halfMeasured = (halfCnt_q == HALF_MAX) ? HALF_MAX : halfCnt_q + 10'h001;

  // Request capture
  wire [7:0] errTally_d = (wrReqTally ? 8'h00 : errTally_q) + {7'h00, auxReq.error};
  wire [7:0] reqTally_d = (wrReqTally ? 8'h00 : reqTally_q) + {7'h00, auxReq.done};
  wire isI2c = !auxReq.command[3];
  wire [19:0] addrKept = isI2c ? {13'h0000, auxReq.address[6:0]} : auxReq.address;
  wire [4:0] lenMinusOne = auxReq.byteCount - 5'h01;
  wire [3:0] lenField = auxReq.addrOnly ? 4'h0 : lenMinusOne[3:0];

  // Interrupt causes
  logic [31:0] causeSet;
  always_comb
  begin
    causeSet = 32'h00000000;
    causeSet[CAUSE_UNPLUG] = linkEvt.unplug;
    causeSet[CAUSE_CRC_START] = linkEvt.crcStart;
    causeSet[CAUSE_ACT_SEQ] = linkEvt.actSeq;
    causeSet[CAUSE_PAYLOAD_ALLOC] = linkEvt.payloadAlloc;
    causeSet[CAUSE_AUDIO_OVF] = linkEvt.audioOverflow;
    causeSet[CAUSE_TPS3] = linkEvt.tps3Start;
    causeSet[CAUSE_TPS2] = linkEvt.tps2Start;
    causeSet[CAUSE_TPS1] = linkEvt.tps1Start;
    causeSet[CAUSE_BW_CHANGE] = linkEvt.bwChange;
    causeSet[CAUSE_TRAIN_DONE] = linkEvt.trainDone;
  end

  // New events win over a clearing read or write
  wire causeClear = rdCause || wrCause;
  wire [31:0] cause_d = (causeClear ? CAUSE_RESET : cause_q) | causeSet;
  wire [31:0] mask_d = wrMask ? hwdata : mask_q;
  wire irq_d = |(cause_d & ~mask_d);

  // Hot-plug pulse
  arsr_hpd_t hpdState_q;
  logic [7:0] usTick_q;
  logic [15:0] usLeft_q;
  logic hpdN_q;

  wire [15:0] durField = hwdata[HPD_DUR_MSB:HPD_DUR_LSB];
  wire [15:0] durUs = (durField == 16'h0000) ? HPD_ZERO_US : durField;
  wire hpdStart = wrHpd && hwdata[HPD_PULSE_LSB];
  wire usTickEnd = usTick_q == US_TICK_LAST;
  wire hpdLast = usTickEnd && (usLeft_q == 16'h0001);

  // Read data, selected in the address phase; unmapped offsets read zero
  logic [31:0] rdMux;
  always_comb
  begin
    rdMux = 32'h00000000;
    if (!inRange)
      rdMux = 32'h00000000;
    else if (rdAddr == OFF_REQ_ACTIVE)
      rdMux = {31'h0, auxReq.active};
    else if (rdAddr == OFF_ERR_TALLY)
      rdMux = {24'h0, errTally_q};
    else if (rdAddr == OFF_REQ_TALLY)
      rdMux = {24'h0, reqTally_q};
    else if (rdAddr == OFF_HPD_CMD)
      rdMux = 32'h00000000;
    else if (rdAddr == OFF_SYNC_HALF)
      rdMux = {22'h0, syncHalf_q};
    else if (rdAddr == OFF_LAST_CMD)
      rdMux = {28'h0, lastCmd_q};
    else if (rdAddr == OFF_LAST_ADDR)
      rdMux = {12'h0, lastAddr_q};
    else if (rdAddr == OFF_LAST_LEN)
      rdMux = {28'h0, lastLen_q};
    else if (rdAddr == OFF_CAUSE)
      rdMux = cause_q;
    else if (rdAddr == OFF_MASK)
      rdMux = mask_q;
  end

  // Read address phase loads the word that the next edge hands over
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hrdata_q <= 32'h00000000;
    else if (rdTake)
      hrdata_q <= rdMux;
  end

  // Zero wait states, always an OKAY response
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hreadyout_q <= 1'b0;
      hresp_q <= 1'b0;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // Writes land at the end of their data phase, while hwdata stands
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wrPend_q <= 1'b0;
    else if (hready)
      wrPend_q <= wrTake && inRange;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wrAddr_q <= 8'h00;
    else if (wrTake)
      wrAddr_q <= rdAddr;
  end

  // Request and error tallies wrap at eight bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      errTally_q <= 8'h00;
      reqTally_q <= 8'h00;
    end
    else
    begin
      errTally_q <= errTally_d;
      reqTally_q <= reqTally_d;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cause_q <= CAUSE_RESET;
      mask_q <= MASK_RESET;
      hostIrq_q <= 1'b0;
    end
    else
    begin
      cause_q <= cause_d;
      mask_q <= mask_d;
      hostIrq_q <= irq_d;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lastCmd_q <= 4'h0;
      lastAddr_q <= 20'h00000;
      lastLen_q <= 4'h0;
    end
    else if (auxReq.done)
    begin
      lastCmd_q <= auxReq.command;
      lastAddr_q <= addrKept;
      lastLen_q <= lenField;
    end
  end

  // Three-stage sampler; a level counts once stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      linkSync_q <= SYNC_RESET;
      linkLvl_q <= 1'b0;
    end
    else
    begin
      linkSync_q <= {linkSync_q[1:0], auxLinkClk};
      if (linkEdge)
        linkLvl_q <= linkSync_q[2];
    end
  end

  // Cycles since the last accepted edge, held at the top of the range
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      halfCnt_q <= 10'h000;
    else
      halfCnt_q <= halfCnt_d;
  end

  // The first edge of a preamble only starts the timing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      syncEdgeSeen_q <= 1'b0;
    else if (!auxReq.inSync)
      syncEdgeSeen_q <= 1'b0;
    else if (linkEdge)
      syncEdgeSeen_q <= 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      syncHalf_q <= 10'h000;
    else if (captureHalf)
      syncHalf_q <= halfMeasured;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hpdState_q <= HPD_IDLE;
      usTick_q <= 8'h00;
      usLeft_q <= 16'h0000;
      hpdN_q <= 1'b1;
    end
    else
    begin
      case (hpdState_q)
        HPD_IDLE:
        begin
          if (hpdStart)
          begin
            hpdState_q <= HPD_PULSE;
            usTick_q <= 8'h00;
            usLeft_q <= durUs;
            hpdN_q <= 1'b0;
          end
        end
        HPD_PULSE:
        begin
          if (hpdStart)
          begin
            usTick_q <= 8'h00;
            usLeft_q <= durUs;
          end
          else if (hpdLast)
          begin
            hpdState_q <= HPD_IDLE;
            hpdN_q <= 1'b1;
          end
          else if (usTickEnd)
          begin
            usTick_q <= 8'h00;
            usLeft_q <= usLeft_q - 16'h0001;
          end
          else
            usTick_q <= usTick_q + 8'h01;
        end
        default:
          hpdState_q <= HPD_IDLE;
      endcase
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hpdN = hpdN_q;
  assign hostIrq = hostIrq_q;

endmodule

// ===== rtl/arsr_pkg.sv
package arsr_pkg;

  localparam logic [7:0] OFF_REQ_ACTIVE = 8'h20;
  localparam logic [7:0] OFF_ERR_TALLY = 8'h24;
  localparam logic [7:0] OFF_REQ_TALLY = 8'h28;
  localparam logic [7:0] OFF_HPD_CMD = 8'h2C;
  localparam logic [7:0] OFF_SYNC_HALF = 8'h30;
  localparam logic [7:0] OFF_LAST_CMD = 8'h34;
  localparam logic [7:0] OFF_LAST_ADDR = 8'h38;
  localparam logic [7:0] OFF_LAST_LEN = 8'h3C;
  localparam logic [7:0] OFF_CAUSE = 8'h40;
  localparam logic [7:0] OFF_MASK = 8'h44;

  localparam int HPD_PULSE_LSB = 0;
  localparam int HPD_DUR_LSB = 16;
  localparam int HPD_DUR_MSB = 31;

  localparam int CAUSE_UNPLUG = 31;
  localparam int CAUSE_CRC_START = 30;
  localparam int CAUSE_ACT_SEQ = 29;
  localparam int CAUSE_PAYLOAD_ALLOC = 28;
  localparam int CAUSE_AUDIO_OVF = 27;
  localparam int CAUSE_TPS3 = 18;
  localparam int CAUSE_TPS2 = 17;
  localparam int CAUSE_TPS1 = 16;
  localparam int CAUSE_BW_CHANGE = 15;
  localparam int CAUSE_TRAIN_DONE = 14;

  localparam logic [31:0] MASK_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] CAUSE_RESET = 32'h00000000;
  localparam logic [15:0] HPD_DEFAULT_US = 16'h02EE;

  localparam int CLK_MHZ = 200;
  localparam int US_NS = 1000;
  localparam int CLK_PERIOD_NS = US_NS / CLK_MHZ;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam logic [7:0] US_TICK_LAST = 8'(CYC_PER_US - 1);

  localparam logic [9:0] HALF_MAX = 10'h3FF;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef enum logic [1:0] {HTRANS_IDLE, HTRANS_BUSY, HTRANS_NONSEQ, HTRANS_SEQ} arsr_htrans_t;

  // Request report from the aux receiver logic, same clock domain
  typedef struct packed {
    logic active;
    logic inSync;
    logic done;
    logic error;
    logic addrOnly;
    logic [3:0] command;
    logic [19:0] address;
    logic [4:0] byteCount;
  } arsr_req_t;

  // One-cycle event pulses from the rest of the receiver
  typedef struct packed {
    logic unplug;
    logic crcStart;
    logic actSeq;
    logic payloadAlloc;
    logic audioOverflow;
    logic tps3Start;
    logic tps2Start;
    logic tps1Start;
    logic bwChange;
    logic trainDone;
  } arsr_evt_t;

endpackage

// ===== verification/arsr_regs_properties.sv
module arsr_regs_properties
  import arsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic auxLinkClk,
  input wire arsr_req_t auxReq,
  input wire arsr_evt_t linkEvt,
  input wire logic hpdN,
  input wire logic hostIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take = hsel && hready && htrans[1];
  wire rd = take && !hwrite;
  logic hpdWr_q;
  logic maskWr_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hpdWr_q <= 1'b0;
      maskWr_q <= 1'b0;
    end
    else
    begin
      hpdWr_q <= take && hwrite && haddr == 32'h2C;
      maskWr_q <= maskWr_q || (take && hwrite && haddr == 32'h44);
    end
  end
  chk_hpd_reads_zero: assert property (rd && haddr == 32'h2C |=> hrdata == 32'h0)
    else $error("hot-plug command read not zero");
  chk_active_one_bit: assert property (rd && haddr == 32'h20 |=> hrdata[31:1] == 31'h0)
    else $error("active flag wider than one bit");
  chk_err_tally_width: assert property (rd && haddr == 32'h24 |=> hrdata[31:8] == 24'h0)
    else $error("error tally wider than eight bits");
  chk_req_tally_width: assert property (rd && haddr == 32'h28 |=> hrdata[31:8] == 24'h0)
    else $error("request tally wider than eight bits");
  chk_sync_width: assert property (rd && haddr == 32'h30 |=> hrdata[31:10] == 22'h0)
    else $error("half period wider than ten bits");
  chk_len_width: assert property (rd && haddr == 32'h3C |=> hrdata[31:4] == 28'h0)
    else $error("length wider than four bits");
  chk_hpd_start: assert property (hpdWr_q && hready && hwdata[0] |-> ##[1:2] !hpdN)
    else $error("hot-plug pulse did not start");
  chk_hpd_min: assert property ($fell(hpdN) |-> !hpdN [*8])
    else $error("hot-plug pulse too short");
  chk_irq_masked: assert property (!maskWr_q |-> !hostIrq)
    else $error("interrupt raised while all masked");
  chk_resp_okay: assert property (!hresp)
    else $error("bus response not okay");
  cover property ($fell(hpdN));
  cover property ($rose(hostIrq));
  cover property (rd && haddr == 32'h40);
endmodule
bind arsr_regs arsr_regs_properties u_arsr_regs_properties (.clk, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .auxLinkClk, .auxReq, .linkEvt,
  .hpdN, .hostIrq);

// ===== verification/arsr_src_model.sv
module arsr_src_model
  import arsr_pkg::*;
(
  input wire logic clk,
  output logic auxLinkClk,
  output arsr_req_t auxReq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    auxLinkClk = 1'b0;
    auxReq = '0;
  end
  // Link clock runs only inside the sync preamble; fields are junk outside done
  task automatic send(input logic [3:0] c, input logic [19:0] a, input logic [4:0] n,
    input logic ao, input logic er);
    @(posedge clk);
    auxReq <= {5'b11000, ~c, ~a, ~n};
    repeat (16) #24 auxLinkClk = ~auxLinkClk;
    @(posedge clk);
    auxReq <= {3'b101, er, ao, c, a, n};
    @(posedge clk);
    auxReq <= {4'h0, ~ao, ~c, ~a, ~n};
  endtask
endmodule

// ===== verification/arsr_regs_tb.sv
module arsr_regs_tb;
  import arsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, auxLinkClk, hpdN, hostIrq, ao, er;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [19:0] adr;
  logic [4:0] n;
  logic [3:0] cmd;
  logic [7:0] nReq, nErr;
  arsr_req_t auxReq;
  arsr_evt_t linkEvt;
  int nFail, testsRun, cnt;
  int pos[10] = '{31, 30, 29, 28, 27, 18, 17, 16, 15, 14};
  arsr_regs #(.HPD_ZERO_US(16'h0002)) u_arsr_regs (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .auxLinkClk, .auxReq,
    .linkEvt, .hpdN, .hostIrq);
  arsr_src_model u_arsr_src_model (.clk, .auxLinkClk, .auxReq);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'($urandom));
    check(rv, e);
  endtask
  task automatic pulse(input logic [9:0] e);
    @(posedge clk);
    linkEvt <= arsr_evt_t'(e);
    @(posedge clk);
    linkEvt <= '0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] expAddr(input logic [3:0] c, input logic [19:0] a);
    return c[3] ? {12'h0, a} : {25'h0, a[6:0]};
  endfunction
  task automatic close_out;
    if (nFail == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, nFail, testsRun, nReq, nErr} = '0;
    linkEvt = '0;
    rst = 1'b1;
    void'($urandom(42));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int a = 32; a <= 64; a += 4)
      rdchk(8'(a), 32'h0);
    rdchk(OFF_MASK, MASK_RESET);
    pulse(10'h001);
    check({31'h0, hostIrq}, 32'h0);
    rdchk(OFF_CAUSE, 32'h1 << CAUSE_TRAIN_DONE);
    rdchk(8'h80, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      cmd = 4'($urandom);
      if (i < 2)
        cmd[3] = i[0];
      adr = 20'($urandom);
      n = (i == 0) ? 5'h10 : (i == 1) ? 5'h01 : 5'($urandom_range(16, 1));
      ao = (i == 3);
      er = i[0];
      fork
        u_arsr_src_model.send(cmd, adr, n, ao, er);
        if (i == 2)
        begin
          repeat (12) @(posedge clk);
          rdchk(OFF_REQ_ACTIVE, 32'h1);
        end
      join
      nReq++;
      nErr += 8'(er);
      rdchk(OFF_LAST_CMD, {28'h0, cmd});
      rdchk(OFF_LAST_ADDR, expAddr(cmd, adr));
      rdchk(OFF_LAST_LEN, ao ? 32'h0 : 32'(n - 5'h1));
    end
    rdchk(OFF_REQ_TALLY, {24'h0, nReq});
    rdchk(OFF_ERR_TALLY, {24'h0, nErr});
    xfer(1'b0, OFF_SYNC_HALF, 32'h0);
    check({31'h0, rv == 32'h4 || rv == 32'h5}, 32'h1);
    xfer(1'b1, OFF_REQ_TALLY, 32'($urandom));
    rdchk(OFF_REQ_TALLY, 32'h0);
    rdchk(OFF_ERR_TALLY, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      xfer(1'b1, OFF_HPD_CMD, k ? 32'h1 : 32'h00030001);
      cnt = 0;
      @(negedge hpdN);
      @(negedge clk);
      while (hpdN === 1'b0)
      begin
        cnt++;
        @(negedge clk);
      end
      check(32'(cnt), k ? 32'd400 : 32'd600);
    end
    rdchk(OFF_HPD_CMD, 32'h0);
    xfer(1'b1, OFF_MASK, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      pulse(10'h200 >> i);
      check({31'h0, hostIrq}, 32'h1);
      rdchk(OFF_CAUSE, 32'h1 << pos[i]);
      rdchk(OFF_CAUSE, 32'h0);
    end
    xfer(1'b1, OFF_MASK, MASK_RESET);
    pulse(10'h200);
    check({31'h0, hostIrq}, 32'h0);
    xfer(1'b1, OFF_CAUSE, 32'($urandom));
    rdchk(OFF_CAUSE, 32'h0);
    close_out();
  end
  initial
  begin
    #200000;
    nFail++;
    close_out();
  end
endmodule
